//--- verilog/cfg_msg_access.sv
/*
  Configuration message interpreter: takes token-framed read and write
  messages for the tile and node register banks and read messages for the
  peripheral bank, performs the access on a request/acknowledge port and
  returns the reply tokens.
  Assumes the register side answers every REG_REQ with one REG_ACK pulse and
  that the interconnect supplies the channel destination with each token.
*/
// Summary of operation
// RULE1 - Every request carries a 24-bit return identifier naming the reply channel-end.
// RULE2 - A write whose return identifier ends in an all-ones byte is done without a reply.
// RULE3 - Fields wider than a byte travel most significant byte first.
// RULE4 - A processor status resource identifier is the register number shifted by 8 ORed with 0x0C.
// RULE5 - Tile configuration messages arrive at the tile identifier with low tag C20C.
// RULE6 - Node configuration messages arrive at the node identifier with low tag C30C.
// RULE7 - Peripheral messages arrive at node identifier, peripheral number and low byte 02.
// RULE8 - A write is token 192, return identifier, 16-bit register, 32-bit data, token 1.
// RULE9 - A read is token 193, return identifier, 16-bit register, token 1.
// RULE10 - A write is answered by tokens 3 and 1 on success or 4 and 1 on failure.
// RULE11 - A read is answered by token 3, 32 data bits and token 1, or by tokens 4 and 1.
// RULE12 - Node and tile banks share message formats and differ only by destination.
// RULE13 - A peripheral read is token 37, return identifier, 8-bit register, 8-bit size, token 1.
// RULE14 - A good peripheral read returns token 3, the requested bytes and token 1.
// RULE15 - An unknown leading token or a missing closing token gives a failure reply; the code sends none for a write with an all-ones last return byte.
`timescale 1ns/10ps

module cfg_msg_access
  import cfg_msg_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // Own identity
  input  wire logic [15:0] TILE_ID,
  input  wire logic [15:0] NODE_ID,
  // Incoming tokens
  input  wire logic        IN_VALID,
  input  wire logic        IN_CTRL,
  input  wire logic [7:0]  IN_DATA,
  input  wire logic [31:0] IN_DEST,
  output logic             IN_READY,
  // Reply tokens
  output logic             OUT_VALID,
  output logic             OUT_CTRL,
  output logic [7:0]       OUT_DATA,
  output logic [23:0]      OUT_RETURN_ID,
  input  wire logic        OUT_READY,
  // Register access
  output logic             REG_REQ,
  output logic             REG_WRITE,
  output logic [1:0]       REG_BANK,
  output logic [7:0]       REG_PERIPH,
  output logic [15:0]      REG_ADDR,
  output logic [31:0]      REG_WDATA,
  input  wire logic        REG_ACK,
  input  wire logic        REG_ERR,
  input  wire logic [31:0] REG_RDATA
);

  typedef enum logic [3:0] {
    S_HDR, S_RET, S_REG, S_SIZE, S_DATA, S_END, S_DRAIN, S_ACCESS, S_REPLY
  } msg_state_t;

  msg_state_t  state;
  msg_state_t  next_state;
  logic [1:0]  cnt;
  logic [1:0]  next_cnt;
  logic [23:0] ret_id;
  logic        is_pread;
  logic [7:0]  psize;
  logic        tx_done;

  // ==========================================================
  // Token and destination decode
  wire take      = IN_VALID && IN_READY;
  wire take_data = take && !IN_CTRL;
  wire take_ctrl = take && IN_CTRL;

  wire dest_tile   = IN_DEST[31:16] == TILE_ID && IN_DEST[15:0] == DEST_TILE_LOW;  // see RULE5
  wire dest_node   = IN_DEST[31:16] == NODE_ID && IN_DEST[15:0] == DEST_NODE_LOW;  // see RULE6
  wire dest_periph = IN_DEST[31:16] == NODE_ID && IN_DEST[7:0] == DEST_PERIPH_LOW; // see RULE7

  // Node and tile banks take the same two headers
  wire cfg_hdr = (IN_DATA == CT_WRITE || IN_DATA == CT_READ) && (dest_tile || dest_node); // see RULE12
  wire per_hdr = IN_DATA == CT_PREAD && dest_periph;  // see RULE13
  wire hdr_ok  = cfg_hdr || per_hdr;

  wire size_bad = is_pread && (psize == 8'h00 || psize > PSIZE_MAX);
  wire quiet    = REG_WRITE && ret_id[7:0] == RET_SILENT;  // see RULE2
  // Full state width: a one-bit net here would fold every failure back to idle
  msg_state_t fail_dst;
  assign fail_dst = quiet ? S_HDR : S_REPLY;
  wire cnt_zero = cnt == 2'h0;

  wire tx_start = next_state == S_REPLY && state != S_REPLY;
  wire tx_fail  = state != S_ACCESS || REG_ERR;
  wire [2:0] tx_len = REG_WRITE ? 3'h0 : (is_pread ? psize[2:0] : CFG_READ_LEN);

  // ==========================================================
  // Message sequencing
  always_comb begin
    next_state = state;
    case (state)
      S_HDR:   if (take) next_state = (IN_CTRL && hdr_ok) ? S_RET : S_DRAIN;  // see RULE15
      S_RET:   if (take_ctrl) next_state = msg_state_t'(fail_dst);
               else if (take && cnt_zero) next_state = S_REG;  // see RULE1
      S_REG:   if (take_ctrl) next_state = msg_state_t'(fail_dst);
               else if (take && cnt_zero)
                 next_state = is_pread ? S_SIZE : (REG_WRITE ? S_DATA : S_END);  // see RULE8 see RULE9
      S_SIZE:  if (take_ctrl) next_state = msg_state_t'(fail_dst);
               else if (take) next_state = S_END;
      S_DATA:  if (take_ctrl) next_state = msg_state_t'(fail_dst);
               else if (take && cnt_zero) next_state = S_END;
      S_END:   if (take_data) next_state = S_DRAIN;
               else if (take_ctrl)
                 next_state = (IN_DATA == CT_END && !size_bad) ? S_ACCESS
                                                                : msg_state_t'(fail_dst); // see RULE15
      S_DRAIN: if (take_ctrl) next_state = msg_state_t'(fail_dst);  // see RULE15
      S_ACCESS: if (REG_ACK) next_state = quiet ? S_HDR : S_REPLY;  // see RULE2
      S_REPLY: if (tx_done) next_state = S_HDR;
      default: next_state = S_HDR;
    endcase
  end

  // Byte counter restarts at each field boundary
  always_comb begin
    next_cnt = cnt;
    if (next_state != state) begin
      case (next_state)
        S_RET:   next_cnt = RET_LAST;
        S_REG:   next_cnt = is_pread ? PER_REG_LAST : CFG_REG_LAST;
        S_DATA:  next_cnt = DATA_LAST;
        default: next_cnt = 2'h0;
      endcase
    end else if (take_data && !cnt_zero) begin
      next_cnt = cnt - 2'h1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state    <= S_HDR;
      cnt      <= 2'h0;
      IN_READY <= 1'b0;
      REG_REQ  <= 1'b0;
    end else begin
      state    <= next_state;
      cnt      <= next_cnt;
      // Hold off the sender while the bank or the reply is busy
      IN_READY <= next_state != S_ACCESS && next_state != S_REPLY;
      REG_REQ  <= next_state == S_ACCESS;
    end
  end

  // ==========================================================
  // Field capture, most significant byte first
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ret_id     <= RET_RESET;
      REG_ADDR   <= 16'h0000;
      REG_WDATA  <= WORD_RESET;
      REG_WRITE  <= 1'b0;
      REG_BANK   <= BANK_TILE;
      REG_PERIPH <= 8'h00;
      is_pread   <= 1'b0;
      psize      <= 8'h00;
    end else if (state == S_HDR && take_ctrl) begin
      REG_ADDR   <= 16'h0000;
      REG_WRITE  <= IN_DATA == CT_WRITE;
      is_pread   <= IN_DATA == CT_PREAD;
      REG_BANK   <= dest_periph ? BANK_PERIPH : (dest_node ? BANK_NODE : BANK_TILE);
      REG_PERIPH <= IN_DEST[15:8];
    end else if (take_data) begin
      case (state)
        S_RET:   ret_id    <= {ret_id[15:0], IN_DATA};     // see RULE3
        S_REG:   REG_ADDR  <= {REG_ADDR[7:0], IN_DATA};    // see RULE3
        S_SIZE:  psize     <= IN_DATA;
        S_DATA:  REG_WDATA <= {REG_WDATA[23:0], IN_DATA};  // see RULE3
        default: psize     <= psize;
      endcase
    end
  end

  assign OUT_RETURN_ID = ret_id;

  // ==========================================================
  // Reply transmitter
  cfg_reply_tx u_tx (
    .clk       (REF_CLK),
    .reset     (RESET),
    .start     (tx_start),
    .fail      (tx_fail),
    .word      (REG_RDATA),
    .nbytes    (tx_len),
    .done      (tx_done),
    .out_valid (OUT_VALID),
    .out_ctrl  (OUT_CTRL),
    .out_data  (OUT_DATA),
    .out_ready (OUT_READY)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_access_done;
    state == S_ACCESS && REG_ACK;
  endsequence

  sequence s_reply_head(logic [7:0] tok);
    OUT_VALID && OUT_CTRL && OUT_DATA == tok;
  endsequence

  a_silent_write: assert property (  // see RULE2
    s_access_done and (REG_WRITE && ret_id[7:0] == RET_SILENT) |=> state == S_HDR && !OUT_VALID
  ) else $error("silent write produced a reply");

  a_write_reply: assert property (  // see RULE10
    s_access_done and (REG_WRITE && ret_id[7:0] != RET_SILENT)
      |=> s_reply_head($past(REG_ERR) ? CT_NACK : CT_ACK)
  ) else $error("write reply head token wrong");

  a_read_reply: assert property (  // see RULE11
    s_access_done and (!REG_WRITE && !is_pread && !REG_ERR) |=> s_reply_head(CT_ACK)
  ) else $error("read reply head token wrong");

  a_bad_frame_fail: assert property (  // see RULE15
    (state == S_DRAIN && take_ctrl && !quiet) |=> s_reply_head(CT_NACK)
  ) else $error("bad message not answered with failure");

  a_tile_decode: assert property (  // see RULE5
    (state == S_HDR && take_ctrl && IN_DATA == CT_READ && dest_tile && !dest_node)
      |=> state == S_RET && REG_BANK == BANK_TILE
  ) else $error("tile destination not taken");

  a_node_decode: assert property (  // see RULE6
    (state == S_HDR && take_ctrl && IN_DATA == CT_WRITE && dest_node)
      |=> REG_BANK == BANK_NODE && REG_WRITE
  ) else $error("node destination not taken");

  a_periph_start: assert property (  // see RULE13
    (state == S_END && take_ctrl && IN_DATA == CT_END && is_pread && !size_bad)
      |=> REG_REQ && REG_BANK == BANK_PERIPH && !IN_READY
  ) else $error("peripheral read access not started");

  a_ret_shift: assert property (  // see RULE3
    (state == S_RET && take_data) |=> ret_id[7:0] == $past(IN_DATA) && ret_id[15:8] == $past(ret_id[7:0])
  ) else $error("return identifier not shifted in order");

  a_req_held: assert property (  // see RULE8
    (REG_REQ && !REG_ACK) |=> REG_REQ && $stable(REG_ADDR) && $stable(REG_WDATA)
  ) else $error("register request dropped before acknowledge");

endmodule

//--- verilog/cfg_msg_pkg.sv
/*
  Constants shared by the configuration message interpreter and its reply
  transmitter: token codes, destination tags, field counts and bank codes.
  Assumes tokens arrive one per clock as an 8-bit value plus a control flag.
*/
package cfg_msg_pkg;

  // ==========================================================
  // Control token codes
  localparam logic [7:0] CT_WRITE  = 8'hc0;
  localparam logic [7:0] CT_READ   = 8'hc1;
  localparam logic [7:0] CT_PREAD  = 8'h25;
  localparam logic [7:0] CT_ACK    = 8'h03;
  localparam logic [7:0] CT_NACK   = 8'h04;
  localparam logic [7:0] CT_END    = 8'h01;

  // ==========================================================
  // Destination tags in the low part of a channel-end destination
  localparam logic [15:0] DEST_TILE_LOW   = 16'hc20c;
  localparam logic [15:0] DEST_NODE_LOW   = 16'hc30c;
  localparam logic [7:0]  DEST_PERIPH_LOW = 8'h02;

  // Return identifier low byte that suppresses a write reply
  localparam logic [7:0]  RET_SILENT = 8'hff;

  // ==========================================================
  // Field lengths, as last-byte counts; read reply length and size limit as byte counts
  localparam logic [1:0] RET_LAST      = 2'h2;
  localparam logic [1:0] CFG_REG_LAST  = 2'h1;
  localparam logic [1:0] PER_REG_LAST  = 2'h0;
  localparam logic [1:0] DATA_LAST     = 2'h3;
  localparam logic [2:0] CFG_READ_LEN  = 3'h4;
  localparam logic [7:0] PSIZE_MAX     = 8'h04;

  // ==========================================================
  // Register bank selection
  localparam logic [1:0] BANK_TILE   = 2'h0;
  localparam logic [1:0] BANK_NODE   = 2'h1;
  localparam logic [1:0] BANK_PERIPH = 2'h2;

  // Reset values
  localparam logic [23:0] RET_RESET  = 24'h000000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;

endpackage

//--- verilog/cfg_reply_tx.sv
/*
  Reply transmitter: sends an acknowledge or failure token, an optional run
  of data bytes taken most significant first from a word, and a closing token.
  Assumes the receiver accepts a token when out_valid and out_ready are high.
*/
`timescale 1ns/10ps

module cfg_reply_tx
  import cfg_msg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Reply request
  input  wire logic        start,
  input  wire logic        fail,
  input  wire logic [31:0] word,
  input  wire logic [2:0]  nbytes,
  output logic             done,
  // Token output
  output logic             out_valid,
  output logic             out_ctrl,
  output logic [7:0]       out_data,
  input  wire logic        out_ready
);

  typedef enum logic [1:0] {T_IDLE, T_HEAD, T_DATA, T_TAIL} tx_state_t;

  tx_state_t   state;
  logic [2:0]  rem;
  logic [31:0] word_q;

  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] idx);
    pick = w[{idx, 3'h0} +: 8];
  endfunction

  wire       moved  = out_valid && out_ready;
  wire [2:0] rem_m1 = rem - 3'h1;
  wire [2:0] rem_m2 = rem - 3'h2;

  // ==========================================================
  // Token sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= T_IDLE;
      rem       <= 3'h0;
      word_q    <= WORD_RESET;
      out_valid <= 1'b0;
      out_ctrl  <= 1'b0;
      out_data  <= 8'h00;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        T_IDLE: if (start) begin
          out_valid <= 1'b1;
          out_ctrl  <= 1'b1;
          out_data  <= fail ? CT_NACK : CT_ACK;  // see RULE10 see RULE11
          word_q    <= word;
          rem       <= fail ? 3'h0 : nbytes;
          state     <= T_HEAD;
        end
        T_HEAD: if (moved) begin
          if (rem != 3'h0) begin
            out_ctrl <= 1'b0;
            out_data <= pick(word_q, rem_m1[1:0]);  // see RULE3
            state    <= T_DATA;
          end else begin
            out_data <= CT_END;
            state    <= T_TAIL;
          end
        end
        T_DATA: if (moved) begin
          rem <= rem_m1;
          if (rem == 3'h1) begin
            out_ctrl <= 1'b1;
            out_data <= CT_END;  // see RULE14
            state    <= T_TAIL;
          end else begin
            out_data <= pick(word_q, rem_m2[1:0]);
          end
        end
        T_TAIL: if (moved) begin
          out_valid <= 1'b0;
          done      <= 1'b1;
          state     <= T_IDLE;
        end
        default: state <= T_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_data_msb_first: assert property (  // see RULE3
    (state == T_HEAD && moved && rem != 3'h0) |=> out_data == word_q[{rem_m1[1:0], 3'h0} +: 8]
  ) else $error("reply data byte out of order");

  a_data_then_end: assert property (  // see RULE14
    (state == T_DATA && moved && rem == 3'h1) |=> out_ctrl && out_data == CT_END
  ) else $error("reply data not closed by end token");

endmodule

//--- bench/reg_bank_model.sv
/*
  Register bank stand-in on the interpreter's access port: answers each
  request after a random wait, returning data derived from the address.
  Assumes REG_* stay steady from request until the edge after the pulse.
*/
`timescale 1ns/10ps

module reg_bank_model (
  // Clock
  input  wire logic        clk,
  // Access port
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [31:0] wdata,
  output logic             ack,
  output logic             err,
  output logic [31:0]      rdata,
  // Control and trace
  input  wire logic        fail_next,
  output logic [31:0]      n_access,
  output logic [31:0]      last_wdata
);
  int unsigned wait_n;

  initial begin
    ack = 1'b0;
    err = 1'b0;
    rdata = 32'h5a5a5a5a;
    n_access = 32'h0;
    last_wdata = 32'h0;
    wait_n = 0;
  end

  // ==========================================================
  // Responder; outside the pulse err and rdata churn so stale use shows
  always @(negedge clk) begin
    if (ack) begin
      ack <= 1'b0;
      err <= ~err;
      rdata <= ~rdata;
      wait_n <= $urandom % 4;
    end else if (req && wait_n != 0) begin
      wait_n <= wait_n - 1;
    end else if (req) begin
      ack <= 1'b1;
      err <= fail_next;
      rdata <= {addr, ~addr};
      n_access <= n_access + 1;
      if (wr) last_wdata <= wdata;
    end
  end
endmodule

//--- bench/tb.sv
/*
  Self-checking bench for the configuration message interpreter.
  Assumes the register bank stand-in answers every access request.
*/
`timescale 1ns/10ps

module tb import cfg_msg_pkg::*;;
  logic        REF_CLK, RESET, IN_VALID, IN_CTRL, IN_READY;
  logic        OUT_VALID, OUT_CTRL, OUT_READY, REG_REQ, REG_WRITE, REG_ACK, REG_ERR;
  logic [15:0] TILE_ID, NODE_ID, REG_ADDR;
  logic [7:0]  IN_DATA, OUT_DATA, REG_PERIPH;
  logic [31:0] IN_DEST, REG_WDATA, REG_RDATA, n_access, last_wdata, dest_v;
  logic [23:0] OUT_RETURN_ID, rid;
  logic [1:0]  REG_BANK;
  logic        fail_next;
  logic [8:0]  rq[$];
  int          bad_count, n_compared, n_test;

  cfg_msg_access uut (.REF_CLK(REF_CLK), .RESET(RESET), .TILE_ID(TILE_ID),
    .NODE_ID(NODE_ID), .IN_VALID(IN_VALID), .IN_CTRL(IN_CTRL), .IN_DATA(IN_DATA),
    .IN_DEST(IN_DEST), .IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_CTRL(OUT_CTRL),
    .OUT_DATA(OUT_DATA), .OUT_RETURN_ID(OUT_RETURN_ID), .OUT_READY(OUT_READY),
    .REG_REQ(REG_REQ), .REG_WRITE(REG_WRITE), .REG_BANK(REG_BANK), .REG_PERIPH(REG_PERIPH),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK), .REG_ERR(REG_ERR),
    .REG_RDATA(REG_RDATA));

  reg_bank_model bank (.clk(REF_CLK), .req(REG_REQ), .wr(REG_WRITE), .addr(REG_ADDR),
    .wdata(REG_WDATA), .ack(REG_ACK), .err(REG_ERR), .rdata(REG_RDATA),
    .fail_next(fail_next), .n_access(n_access), .last_wdata(last_wdata));

  // ==========================================================
  // Clock, reply sink with random stalls, watchdog
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  always @(negedge REF_CLK) begin
    OUT_READY = ($urandom % 4) != 0;
    if (OUT_VALID && OUT_READY) begin
      rq.push_back({OUT_CTRL, OUT_DATA});
      rid = OUT_RETURN_ID;
    end
  end

  initial begin
    #(40 * 40000);
    bad_count++;
    give_verdict();
  end

  // ==========================================================
  // Shared tasks
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic send_tok(input logic c, input logic [7:0] d);
    int n;
    @(negedge REF_CLK);
    IN_VALID = 1'b1;
    IN_CTRL = c;
    IN_DATA = d;
    IN_DEST = dest_v;
    n = 0;
    while (IN_READY !== 1'b1 && n < 200) begin
      @(negedge REF_CLK);
      n++;
    end
    if (n >= 200) bad_count++;
    @(posedge REF_CLK);
  endtask

  task automatic do_msg(input logic [7:0] hdr, input logic [31:0] dst, input logic [23:0] ret,
                        input logic [15:0] rg, input logic [31:0] wd, input logic [7:0] psz,
                        input logic ok, input logic [7:0] close);
    logic [8:0]  exp[$];
    logic        acc, per, silent, good;
    logic [31:0] rd, n0;
    int          n, nb;
    per = (hdr == CT_PREAD);
    acc = (close == CT_END) && (per ? (dst[31:16] == NODE_ID && dst[7:0] == DEST_PERIPH_LOW
          && psz >= 8'h01 && psz <= PSIZE_MAX) : ((hdr == CT_WRITE || hdr == CT_READ)
          && (dst == {TILE_ID, DEST_TILE_LOW} || dst == {NODE_ID, DEST_NODE_LOW})));
    silent = (hdr == CT_WRITE) && (ret[7:0] == RET_SILENT);
    good = acc && ok;
    rd = per ? {8'h00, rg[7:0], 8'hff, ~rg[7:0]} : {rg, ~rg};
    nb = !good ? 0 : (hdr == CT_READ) ? 4 : per ? int'(psz) : 0;
    if (!silent) exp.push_back({1'b1, good ? CT_ACK : CT_NACK});
    for (int i = nb - 1; i >= 0 && !silent; i--) exp.push_back({1'b0, rd[8*i+:8]});
    if (!silent) exp.push_back({1'b1, CT_END});
    fail_next = !ok;
    rq = {};
    n0 = n_access;
    dest_v = dst;
    send_tok(1'b1, hdr);
    for (int i = 2; i >= 0; i--) send_tok(1'b0, ret[8*i+:8]);
    if (!per) send_tok(1'b0, rg[15:8]);
    send_tok(1'b0, rg[7:0]);
    if (per) send_tok(1'b0, psz);
    for (int i = 3; i >= 0 && hdr == CT_WRITE; i--) send_tok(1'b0, wd[8*i+:8]);
    send_tok(1'b1, close);
    @(negedge REF_CLK);
    IN_VALID = 1'b0;
    n = 0;
    while (acc && REG_REQ !== 1'b1 && n < 20) begin
      @(negedge REF_CLK);
      n++;
    end
    if (acc && n >= 20) bad_count++;
    if (acc) begin
      chk(REG_WRITE, hdr == CT_WRITE);
      chk(REG_BANK, per ? BANK_PERIPH : dst[15:0] == DEST_NODE_LOW ? BANK_NODE : BANK_TILE);
      chk(REG_ADDR, per ? {8'h00, rg[7:0]} : rg);
      if (per) chk(REG_PERIPH, dst[15:8]);
      if (hdr == CT_WRITE) chk(REG_WDATA, wd);
    end
    n = 0;
    while (IN_READY !== 1'b1 && n < 400) begin
      @(negedge REF_CLK);
      n++;
    end
    if (n >= 400) bad_count++;
    @(negedge REF_CLK);
    chk(n_access - n0, acc);
    chk(rq.size(), exp.size());
    for (int i = 0; i < exp.size() && i < rq.size(); i++) chk(rq[i], exp[i]);
    if (exp.size() != 0 && acc) chk(rid, ret);
    n_test++;
    $display("test %0d done hdr=%h", n_test, hdr);
  endtask

  // Processor status resource identifier of a register number
  function automatic logic [15:0] ps_res(input logic [7:0] r);
    ps_res = {r, 8'h00} | 16'h000c;
  endfunction

  // A control token in mid-field cuts the message: failure reply, no access
  task automatic cut_msg(input logic [23:0] ret);
    logic [31:0] n0;
    int          n;
    rq = {};
    n0 = n_access;
    fail_next = 1'b0;
    dest_v = {TILE_ID, DEST_TILE_LOW};
    send_tok(1'b1, CT_WRITE);
    for (int i = 2; i >= 0; i--) send_tok(1'b0, ret[8*i+:8]);
    send_tok(1'b0, 8'h00);
    send_tok(1'b1, CT_END);
    @(negedge REF_CLK);
    IN_VALID = 1'b0;
    n = 0;
    while (IN_READY !== 1'b1 && n < 400) begin
      @(negedge REF_CLK);
      n++;
    end
    if (n >= 400) bad_count++;
    @(negedge REF_CLK);
    chk(n_access - n0, 32'h0);
    chk(rq.size(), 32'h2);
    if (rq.size() == 2) chk({rq[0], rq[1]}, {1'b1, CT_NACK, 1'b1, CT_END});
    if (rq.size() == 2) chk(rid, ret);
    n_test++;
    $display("test %0d done cut", n_test);
  endtask

  // ==========================================================
  // Main sequence: corner cases, then random traffic
  initial begin
    logic [7:0]  h;
    logic [31:0] d;
    int          k;
    void'($urandom(39));
    RESET = 1'b1;
    IN_VALID = 1'b0;
    IN_CTRL = 1'b0;
    IN_DATA = 8'h00;
    IN_DEST = 32'h0;
    dest_v = 32'h0;
    fail_next = 1'b0;
    TILE_ID = 16'($urandom);
    NODE_ID = TILE_ID ^ 16'h0101;
    repeat (10) @(negedge REF_CLK);
    RESET = 1'b0;
    do_msg(CT_WRITE, {TILE_ID, DEST_TILE_LOW}, 24'h123456, 16'h0102, $urandom, 8'h00, 1'b1, CT_END);
    do_msg(CT_READ, {TILE_ID, DEST_TILE_LOW}, 24'habcdef, 16'hfe01, 32'h0, 8'h00, 1'b1, CT_END);
    do_msg(CT_WRITE, {NODE_ID, DEST_NODE_LOW}, 24'h010203, 16'h0040, $urandom, 8'h00, 1'b0, CT_END);
    do_msg(CT_READ, {NODE_ID, DEST_NODE_LOW}, 24'h0a0b0c, 16'h0041, 32'h0, 8'h00, 1'b0, CT_END);
    for (int s = 0; s <= 5; s++) do_msg(CT_PREAD, {NODE_ID, 8'h07, DEST_PERIPH_LOW}, 24'h111111, 16'h0023, 32'h0, 8'(s), 1'b1, CT_END);
    do_msg(CT_WRITE, {TILE_ID, DEST_TILE_LOW}, 24'h4242ff, 16'h0005, 32'hcafe0001, 8'h00, 1'b1, CT_END);
    do_msg(CT_WRITE, {NODE_ID, DEST_NODE_LOW}, 24'h4242ff, 16'h0006, 32'h0000beef, 8'h00, 1'b0, CT_END);
    chk(last_wdata, 32'h0000beef);
    do_msg(CT_READ, {TILE_ID, DEST_TILE_LOW}, 24'h7777ff, ps_res(8'h07), 32'h0, 8'h00, 1'b1, CT_END);
    do_msg(8'h55, {TILE_ID, DEST_TILE_LOW}, 24'h202020, 16'h0001, 32'h0, 8'h00, 1'b1, CT_END);
    do_msg(CT_WRITE, {TILE_ID, DEST_TILE_LOW}, 24'h303030, 16'h0002, 32'h1, 8'h00, 1'b1, 8'h02);
    do_msg(CT_READ, {TILE_ID ^ 16'h8000, DEST_TILE_LOW}, 24'h404040, 16'h0003, 32'h0, 8'h00, 1'b1, CT_END);
    do_msg(CT_READ, {TILE_ID, DEST_NODE_LOW}, 24'h505050, 16'h0004, 32'h0, 8'h00, 1'b1, CT_END);
    cut_msg(24'h606060);
    for (int i = 0; i < 24; i++) begin
      k = $urandom % 3;
      h = (k == 0) ? CT_WRITE : (k == 1) ? CT_READ : CT_PREAD;
      d = (k == 2) ? {NODE_ID, 8'($urandom), DEST_PERIPH_LOW} :
          ($urandom % 2) ? {TILE_ID, DEST_TILE_LOW} : {NODE_ID, DEST_NODE_LOW};
      do_msg(h, d, 24'($urandom), 16'($urandom), $urandom, 8'($urandom % 4 + 1), ($urandom % 5) != 0, CT_END);
    end
    give_verdict();
  end
endmodule
